// [rtl/otprog_consts.vh]
// Purpose: constants for the one-time array programmer (host side)
// Assumes: 25 MHz clock, 40 ns period
// Notes:   times kept in their own unit; cycle counts derived from them, except the read wait, which is given in cycles
//
// What this block does
// - raise supplies, disable outputs before pulse
// - standard pulse 0.95 to 1.05 ms
// - fast pulse 95 to 105 us
// - overprogram pulse 2.85 to 78.75 ms
// - after each initial pulse read back and compare; the overprogram pulse ends the request
`ifndef OTPROG_CONSTS_VH
`define OTPROG_CONSTS_VH
`define OTPROG_CLK_MHZ        25
`define OTPROG_ADDR_W         15
`define OTPROG_DATA_W         8
`define OTPROG_WORDS          32768
// pulse widths, nominal, in microseconds
`define OTPROG_STD_PULSE_US   1000
`define OTPROG_FAST_PULSE_US  100
// overprogram pulse per initial pulse, in microseconds (3x nominal)
`define OTPROG_OVER_STEP_US   3000
// supply and setup settle time, microseconds
`define OTPROG_SETUP_US       2
`define OTPROG_STD_CYC        (`OTPROG_STD_PULSE_US * `OTPROG_CLK_MHZ)
`define OTPROG_FAST_CYC       (`OTPROG_FAST_PULSE_US * `OTPROG_CLK_MHZ)
`define OTPROG_OVER_STEP_CYC  (`OTPROG_OVER_STEP_US * `OTPROG_CLK_MHZ)
`define OTPROG_SETUP_CYC      (`OTPROG_SETUP_US * `OTPROG_CLK_MHZ)
// read access wait, cycles (covers 250 ns access)
`define OTPROG_READ_CYC       8
`define OTPROG_MAX_TRIES      25
`endif

// [rtl/otprog_timer.v]
// Purpose: down counter giving a done pulse after a loaded cycle count
// Assumes: load has priority over counting
// Notes:   done is a one-cycle registered pulse
`timescale 1ns/1ps
module otprog_timer #(
    parameter W = 22
) (
    input  wire         i_clk,
    input  wire         i_rstn,
    input  wire         i_load,
    input  wire [W-1:0] i_count,
    output reg          o_done
);
    reg [W-1:0] cnt;   // remaining cycles
    reg         run;   // counting in progress

    // count down; done fires as the count steps from one to zero
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt    <= {W{1'b0}};
            run    <= 1'b0;
            o_done <= 1'b0;
        end else if (i_load) begin
            cnt    <= i_count;
            run    <= 1'b1;
            o_done <= 1'b0;
        end else if (run) begin
            cnt    <= cnt - {{(W-1){1'b0}}, 1'b1};
            o_done <= (cnt <= {{(W-1){1'b0}}, 1'b1});
            run    <= (cnt > {{(W-1){1'b0}}, 1'b1});
        end else begin
            o_done <= 1'b0;
        end
    end
endmodule // otprog_timer

// [rtl/otprog_host.v]
// Purpose: host that reads and programs a 32K x 8 one-time array by its pins
// Assumes: pins synchronous to i_clk; supplies switched by external drivers
// Notes:   one request at a time; o_busy high until o_done pulse
`timescale 1ns/1ps
`include "otprog_consts.vh"
module otprog_host #(
    parameter STD_CYC   = `OTPROG_STD_CYC,
    parameter FAST_CYC  = `OTPROG_FAST_CYC,
    parameter OVER_CYC  = `OTPROG_OVER_STEP_CYC,
    parameter SETUP_CYC = `OTPROG_SETUP_CYC,
    parameter MAX_TRIES = `OTPROG_MAX_TRIES
) (
    input  wire                       i_clk,
    input  wire                       i_rstn,
    // user side
    input  wire                       i_req,      // start pulse
    input  wire                       i_write,    // 1 program, 0 read
    input  wire                       i_fast,     // fast pulse algorithm
    input  wire [`OTPROG_ADDR_W-1:0]  i_addr,
    input  wire [`OTPROG_DATA_W-1:0]  i_wdata,
    output reg                        o_busy,
    output reg                        o_done,     // one-cycle pulse
    output reg                        o_fail,     // valid with o_done
    output reg  [`OTPROG_DATA_W-1:0]  o_rdata,
    // device pins
    output reg  [`OTPROG_ADDR_W-1:0]  o_addr,
    output reg                        o_sel_n,    // chip select, low active
    output reg                        o_drive_n,  // output drive, low active
    output reg  [`OTPROG_DATA_W-1:0]  o_data,
    output reg                        o_data_oe,  // high while host drives data
    input  wire [`OTPROG_DATA_W-1:0]  i_data,
    output reg                        o_vpp_hi,   // programming supply on
    output reg                        o_vcc_hi,   // core supply at 6 V
    output reg                        o_vcc_fast  // core supply at 6.25 V
);
    // one-hot states
    localparam S_IDLE  = 8'h01;
    localparam S_RDACC = 8'h02;
    localparam S_PSET  = 8'h04;
    localparam S_PULSE = 8'h08;
    localparam S_VSET  = 8'h10;
    localparam S_VCHK  = 8'h20;
    localparam S_OVER  = 8'h40;
    localparam S_END   = 8'h80;

    reg  [7:0]                state;
    reg  [7:0]                next_state;
    reg  [`OTPROG_DATA_W-1:0] target;    // byte to be held in the array
    reg                       fast;      // latched algorithm choice
    reg                       failed;    // sticky outcome of this request
    reg  [5:0]                tries;     // initial pulses applied
    reg                       tload;
    reg  [31:0]               tcount;
    wire                      tdone;

    // bits whose wanted one is already zero cannot be restored
    function illegal_req;
        input [`OTPROG_DATA_W-1:0] have;
        input [`OTPROG_DATA_W-1:0] want;
        begin
            illegal_req = |(want & ~have);
        end
    endfunction

    // overprogram length grows with the number of initial pulses
    function [31:0] over_len;
        input [5:0] n;
        begin
            over_len = OVER_CYC * {26'h0, n};
        end
    endfunction

    otprog_timer #(.W(32)) u_timer (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_load  (tload),
        .i_count (tcount),
        .o_done  (tdone)
    );

    // next state and timer loads
    always @* begin
        next_state = state;
        tload      = 1'b0;
        tcount     = 32'h0;
        case (state)
            S_IDLE: begin
                if (i_req) begin
                    tload  = 1'b1;
                    // programming waits for supplies to settle
                    tcount = i_write ? SETUP_CYC : `OTPROG_READ_CYC;
                    // a write reads the byte first so a refused one never gets a pulse
                    next_state = i_write ? S_VSET : S_RDACC;
                end
            end
            S_RDACC: if (tdone) next_state = S_END;
            S_PSET: begin
                if (tdone) begin
                    tload      = 1'b1;
                    tcount     = fast ? FAST_CYC : STD_CYC;
                    next_state = S_PULSE;
                end
            end
            S_PULSE: begin
                if (tdone) begin
                    tload      = 1'b1;
                    tcount     = SETUP_CYC;
                    next_state = S_VSET;
                end
            end
            S_VSET: if (tdone) next_state = S_VCHK;
            S_VCHK: begin
                if (i_data == target) begin
                    if (tries != 6'h00) begin
                        // one overprogram pulse sized to the tries so far
                        tload      = 1'b1;
                        tcount     = over_len(tries);
                        next_state = S_OVER;
                    end else begin
                        // byte already held: no pulse at all
                        next_state = S_END;
                    end
                end else if (illegal_req(i_data, target) || tries >= MAX_TRIES[5:0]) begin
                    next_state = S_END;
                end else begin
                    tload      = 1'b1;
                    tcount     = SETUP_CYC;
                    next_state = S_PSET;
                end
            end
            S_OVER: if (tdone) next_state = S_END;
            S_END:  next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // registered pins and status
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state      <= S_IDLE;
            target     <= 8'hFF;
            fast       <= 1'b0;
            failed     <= 1'b0;
            tries      <= 6'h00;
            o_busy     <= 1'b0;
            o_done     <= 1'b0;
            o_fail     <= 1'b0;
            o_rdata    <= 8'h00;
            o_addr     <= 15'h0000;
            o_sel_n    <= 1'b1;   // standby, pins float
            o_drive_n  <= 1'b1;
            o_data     <= 8'h00;
            o_data_oe  <= 1'b0;
            o_vpp_hi   <= 1'b0;
            o_vcc_hi   <= 1'b0;
            o_vcc_fast <= 1'b0;
        end else begin
            state  <= next_state;
            o_done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (i_req) begin
                        o_busy    <= 1'b1;
                        o_addr    <= i_addr;     // fifteen-bit byte address
                        target    <= i_wdata;
                        fast      <= i_fast;
                        failed    <= 1'b0;
                        tries     <= 6'h00;
                        o_sel_n   <= 1'b0;
                        // write keeps outputs off; read enables them
                        o_drive_n <= i_write;
                        o_data    <= i_wdata;
                        o_data_oe <= 1'b0;
                        o_vpp_hi  <= i_write;
                        o_vcc_hi  <= i_write & ~i_fast;
                        o_vcc_fast<= i_write & i_fast;
                        // inhibit while supplies rise
                        if (i_write) o_sel_n <= 1'b1;
                    end
                end
                S_RDACC: if (tdone) o_rdata <= i_data;
                S_PSET: begin
                    // drive data with outputs off
                    o_data_oe <= 1'b1;
                    o_drive_n <= 1'b1;
                    if (tdone) begin
                        o_sel_n <= 1'b0;          // pulse on select
                        tries   <= tries + 6'h01;
                    end
                end
                // data stays driven past the select edge: the array latches it there
                S_PULSE: if (tdone) o_sel_n <= 1'b1;  // end pulse, inhibit
                S_VSET: if (tdone) begin
                    o_data_oe <= 1'b0;            // hold time spent, let the pins go
                    o_drive_n <= 1'b0;            // verify read
                end
                S_VCHK: begin
                    o_rdata   <= i_data;
                    o_drive_n <= 1'b1;
                    if (i_data == target) begin
                        if (tries != 6'h00) begin
                            o_data_oe <= 1'b1;
                            o_sel_n   <= 1'b0;    // overprogram pulse
                        end
                    end else if (illegal_req(i_data, target) || tries >= MAX_TRIES[5:0]) begin
                        // a one wanted where zero is stored can never pass
                        failed <= 1'b1;
                    end
                end
                // data released one cycle later in S_END, again for hold time
                S_OVER: if (tdone) o_sel_n <= 1'b1;
                S_END: begin
                    o_busy     <= 1'b0;
                    o_done     <= 1'b1;
                    o_fail     <= failed;
                    o_sel_n    <= 1'b1;
                    o_drive_n  <= 1'b1;
                    o_data_oe  <= 1'b0;
                    o_vpp_hi   <= 1'b0;
                    o_vcc_hi   <= 1'b0;
                    o_vcc_fast <= 1'b0;
                end
                default: ;
            endcase
        end
    end
endmodule // otprog_host

// [tb/otprog_array_model.sv]
// Purpose: behavioural one-time array seen by the host at its pins
// Assumes: pins settle within a clock; no access timing modelled
// Notes:   i_stuck makes programming ineffective to force a failure
`timescale 1ns/1ps
module otprog_array_model (
    input  wire [14:0] i_addr,
    input  wire        i_sel_n,
    input  wire        i_drive_n,
    input  wire [7:0]  i_hdata,
    input  wire        i_hoe,
    input  wire        i_vpp_hi,
    input  wire        i_vcc_prog,
    input  wire        i_stuck,
    output wire [7:0]  o_bus
);
    reg [7:0] mem [0:32767];  // one byte per fifteen-bit address
    integer   k;
    wire      drv;            // device drives the data pins
    // shipped blank: every bit reads one
    initial for (k = 0; k < 32768; k = k + 1) mem[k] = 8'hFF;
    // a select pulse at program supplies only clears bits
    always @(posedge i_sel_n) begin
        if (i_vpp_hi && i_vcc_prog && i_drive_n && i_hoe && !i_stuck)
            mem[i_addr] <= mem[i_addr] & i_hdata;
    end
    // read, verify, disable, standby, inhibit
    assign drv = i_vpp_hi ? (i_sel_n && !i_drive_n) : (!i_sel_n && !i_drive_n);
    // released pins show the inverse so a stray sample cannot pass
    assign o_bus = i_hoe ? i_hdata : (drv ? mem[i_addr] : ~mem[i_addr]);
endmodule // otprog_array_model

// [tb/otprog_host_monitor.sv]
// Purpose: pin-level checks on the one-time array host
// Assumes: widths of the host top ports
// Notes:   pulse widths judged against the shortened cycle counts
`timescale 1ns/1ps
module otprog_host_monitor #(
    parameter STD_CYC  = 200,
    parameter FAST_CYC = 100
) (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_req,
    input wire logic        i_write,
    input wire logic [7:0]  i_wdata,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic        o_fail,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_sel_n,
    input wire logic        o_drive_n,
    input wire logic        o_data_oe,
    input wire logic        o_vpp_hi,
    input wire logic        o_vcc_hi,
    input wire logic        o_vcc_fast
);
    logic [31:0] cnt;   // cycles of the current select pulse
    logic        wr_q;  // taken request was a program
    logic [7:0]  wd_q;  // byte asked for
    wire std_ok  = cnt * 100 >= STD_CYC * 95 && cnt * 100 <= STD_CYC * 105;
    wire fast_ok = cnt * 100 >= FAST_CYC * 95 && cnt * 100 <= FAST_CYC * 105;
    wire over_ok = cnt * 100 >= STD_CYC * 285 && cnt * 100 <= STD_CYC * 7875;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // pulse counter and captured request
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt  <= '0;
            wr_q <= 1'b0;
            wd_q <= '0;
        end else begin
            cnt <= (!o_sel_n && o_vpp_hi) ? cnt + 1 : '0;
            if (i_req && !o_busy) begin
                wr_q <= i_write;
                wd_q <= i_wdata;
            end
        end
    end
    chk_pulse_setup: assert property (
        $fell(o_sel_n) && o_vpp_hi |-> $past(o_vpp_hi) && (o_vcc_hi || o_vcc_fast))
        else $error("select pulse before supplies settled");
    chk_outputs_off: assert property (
        o_vpp_hi && !o_sel_n |-> o_drive_n && o_data_oe)
        else $error("outputs enabled during a program pulse");
    chk_std_width: assert property (
        $rose(o_sel_n) && o_vpp_hi && o_vcc_hi |-> std_ok || over_ok)
        else $error("standard pulse width out of range");
    chk_fast_width: assert property (
        $rose(o_sel_n) && o_vpp_hi && o_vcc_fast |-> fast_ok || over_ok)
        else $error("fast pulse width out of range");
    chk_verify_follows: assert property (
        $rose(o_sel_n) && o_vpp_hi |-> ##[1:40] (!o_drive_n || o_done))
        else $error("no read back after a pulse");
    chk_verify_mode: assert property (
        !o_drive_n && o_vpp_hi |-> o_sel_n && !o_data_oe)
        else $error("verify with wrong select or contention");
    chk_read_time: assert property (
        $rose(o_busy) && !o_vpp_hi |-> ##10 (o_done && !o_busy))
        else $error("read did not finish on time");
    chk_idle_quiet: assert property (
        !o_busy && !$past(o_busy) |-> o_sel_n && o_drive_n && !o_data_oe && !o_vpp_hi)
        else $error("pins not in standby while idle");
    chk_result_match: assert property (
        o_done && wr_q && !o_fail |-> o_rdata == wd_q)
        else $error("pass reported with wrong byte");
    chk_fail_rise: assert property (
        o_done && wr_q && (~o_rdata & wd_q) != 8'h00 |-> o_fail)
        else $error("zero to one request not reported");
    cov_read: cover property (o_done && !wr_q);
    cov_pass: cover property (o_done && wr_q && !o_fail);
    cov_fail: cover property (o_done && o_fail);
    cov_fast: cover property ($rose(o_sel_n) && o_vcc_fast);
endmodule // otprog_host_monitor
bind otprog_host otprog_host_monitor #(.STD_CYC(STD_CYC), .FAST_CYC(FAST_CYC))
    otprog_host_monitor_i (.*);

// [tb/otprog_host_test.sv]
// Purpose: directed test of the one-time array host against a model
// Assumes: shortened pulse counts, three tries
// Notes:   outputs sampled on the falling edge
`timescale 1ns/1ps
module otprog_host_test;
    logic        i_clk, i_rstn, i_req, i_write, i_fast, stuck;
    logic [14:0] i_addr, o_addr;
    logic [7:0]  i_wdata, o_rdata, o_data, i_data;
    logic        o_busy, o_done, o_fail, o_sel_n, o_drive_n, o_data_oe;
    logic        o_vpp_hi, o_vcc_hi, o_vcc_fast;
    int          failures = 0;
    int          n_checks = 0;
    int          cyc = 0;
    otprog_host #(.STD_CYC(200), .FAST_CYC(100), .OVER_CYC(600), .SETUP_CYC(4),
        .MAX_TRIES(3)) otprog_host_i (.*);
    otprog_array_model otprog_array_model_i (.i_addr(o_addr), .i_sel_n(o_sel_n),
        .i_drive_n(o_drive_n), .i_hdata(o_data), .i_hoe(o_data_oe),
        .i_vpp_hi(o_vpp_hi), .i_vcc_prog(o_vcc_hi | o_vcc_fast), .i_stuck(stuck),
        .o_bus(i_data));
    task print_verdict;
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task cmp(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one request, then wait for done under a bound
    task op(input logic w, input logic f, input logic [14:0] a, input logic [7:0] d);
        int n;
        @(posedge i_clk);
        i_req   <= 1'b1;
        i_write <= w;
        i_fast  <= f;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_req <= 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 5000) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 5000) failures++;
    endtask
    task t_blank;
        op(1'b0, 1'b0, 15'h7FFF, 8'h00);
        cmp(o_rdata, 8'hFF);
        op(1'b0, 1'b0, 15'h0000, 8'h00);
        cmp(o_rdata, 8'hFF);
    endtask
    task t_prog(input logic f, input logic [14:0] a, input logic [7:0] d);
        op(1'b1, f, a, d);
        cmp({7'h00, o_fail}, 8'h00);
        op(1'b0, 1'b0, a, 8'h00);
        cmp(o_rdata, d);
        op(1'b0, 1'b0, a + 15'h0001, 8'h00);
        cmp(o_rdata, 8'hFF);
    endtask
    task t_zero_one;
        op(1'b1, 1'b0, 15'h1234, 8'hF0);
        cmp({7'h00, o_fail}, 8'h01);
        op(1'b0, 1'b0, 15'h1234, 8'h00);
        cmp(o_rdata, 8'hA5);
    endtask
    task t_stuck;
        @(posedge i_clk);
        stuck <= 1'b1;
        op(1'b1, 1'b0, 15'h0100, 8'h0F);
        cmp({7'h00, o_fail}, 8'h01);
        stuck <= 1'b0;
        op(1'b0, 1'b0, 15'h0100, 8'h00);
        cmp(o_rdata, 8'hFF);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // hang guard: whole run needs well under this many cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            print_verdict;
        end
    end
    initial begin
        i_rstn = 1'b0;
        i_req = 1'b0;
        i_write = 1'b0;
        i_fast = 1'b0;
        i_addr = '0;
        i_wdata = '0;
        stuck = 1'b0;
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_blank;
        t_prog(1'b0, 15'h1234, 8'hA5);
        t_prog(1'b1, 15'h0001, 8'h3C);
        t_zero_one;
        t_stuck;
        print_verdict;
    end
endmodule // otprog_host_test
